/* File: rtl/hrci_pkg.sv */
`default_nettype none
package hrci_pkg;
	// ------------------------------------------------------------
	// Holding register layout
	// ------------------------------------------------------------
	localparam int NODES = 4;
	localparam int REG_PER_NODE = 16;
	localparam int MEM_AW = 6;
	localparam int MEM_WORDS = NODES * REG_PER_NODE;
	localparam logic [4:0] IDX_ACK = 5'd7;
	localparam logic [4:0] IDX_MSG = 5'd8;
	localparam logic [4:0] IDX_CTRL = 5'd15;
	localparam logic [4:0] IDX_DATA = 5'd16;
	localparam logic [3:0] OFF_ACK = 4'(IDX_ACK - 5'd1);
	localparam logic [3:0] OFF_MSG = 4'(IDX_MSG - 5'd1);
	localparam logic [3:0] OFF_CTRL = 4'(IDX_CTRL - 5'd1);
	localparam logic [3:0] OFF_DATA = 4'(IDX_DATA - 5'd1);
	localparam logic [15:0] RST_WORD = 16'h0000;
	// ------------------------------------------------------------
	// Control codes and message values
	// ------------------------------------------------------------
	localparam logic [7:0] CODE_RESET_ERR = 8'h04;
	localparam logic [7:0] CODE_IGNORE_ERR = 8'h05;
	localparam logic [7:0] CODE_DISABLE_ERR = 8'h06;
	localparam logic [7:0] NODE_FIRST = 8'h01;
	localparam logic [7:0] NODE_LAST = 8'h2f;
	localparam logic [15:0] MSG_DISABLED = 16'h00fe;
	localparam logic [7:0] CODE_WRITE_IO1 = 8'h81;
	localparam logic [7:0] PARAM_SAMPLE = 8'h03;
	localparam logic [7:0] CODE_PRESET_LO = 8'h8f;
	localparam logic [7:0] CODE_PRESET_HI = 8'h90;
	// ------------------------------------------------------------
	// Output unit codes and full scales (uA, mV, counts)
	// ------------------------------------------------------------
	localparam logic [7:0] UNIT_MA_0_20 = 8'h07;
	localparam logic [7:0] UNIT_SMA_4_20A = 8'h08;
	localparam logic [7:0] UNIT_SMA_4_20B = 8'h09;
	localparam logic [7:0] UNIT_V_0_10 = 8'h0a;
	localparam logic [7:0] UNIT_CNT16 = 8'h0b;
	localparam logic [7:0] UNIT_MA_4_20 = 8'h0c;
	localparam logic [15:0] FS_20MA = 16'h4e20;
	localparam logic [15:0] FS_16MA = 16'h3e80;
	localparam logic [15:0] BASE_4MA = 16'h0fa0;
	localparam logic [15:0] FS_10V = 16'h2710;
	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_PS = 5000;
	localparam longint TICK_PS = 62_500_000_000;
	localparam int TICK_CYCLES = int'((TICK_PS + CLK_PS - 1) / CLK_PS);
	localparam int POLL_MAX = 16;
	// ------------------------------------------------------------
	// Host APB registers
	// ------------------------------------------------------------
	localparam logic [7:0] HA_GO = 8'h00;
	localparam logic [7:0] HA_NODE = 8'h04;
	localparam logic [7:0] HA_ADDR = 8'h08;
	localparam logic [7:0] HA_WORD = 8'h0c;
	localparam logic [7:0] HA_DATA = 8'h10;
	localparam logic [7:0] HA_STATUS = 8'h14;
	localparam logic [7:0] HA_RDATA = 8'h18;
	localparam int GO_PARAM = 0;
	localparam int GO_READ = 1;
	localparam int GO_WRITE = 2;
	localparam int ST_BUSY = 0;
	localparam int ST_DONE = 1;
	localparam int ST_MATCH = 2;
	localparam int ST_LERR = 3;
	typedef enum logic [2:0] {H_IDLE, H_DATA, H_CTRL, H_POLL, H_RAW} hrci_hstate_t;
endpackage : hrci_pkg
`default_nettype wire

/* File: rtl/hrci_link_if.sv */
`timescale 1ns/100ps
`default_nettype none
// Holding register link between host controller and device
interface hrci_link_if;
	logic req;
	logic we;
	logic [15:0] addr;
	logic [15:0] wdata;
	logic [15:0] rdata;
	logic ack;
	logic err;
	modport device (input req, we, addr, wdata, output rdata, ack, err);
	modport host (output req, we, addr, wdata, input rdata, ack, err);
endinterface : hrci_link_if
`default_nettype wire

/* File: rtl/hrci_device.sv */
`timescale 1ns/100ps
`default_nettype none
module hrci_device #(
	parameter int TICK_CYCLES = hrci_pkg::TICK_CYCLES
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Holding register link
	hrci_link_if.device link,
	// Error message reports
	input wire logic err_valid,
	input wire logic [7:0] err_node,
	input wire logic [7:0] err_code,
	// Counter events and node outputs
	input wire logic [hrci_pkg::NODES-1:0][1:0] count_pulse,
	output logic [hrci_pkg::NODES-1:0][1:0][31:0] event_count,
	output logic [hrci_pkg::NODES-1:0][15:0] sample_interval,
	output logic [hrci_pkg::NODES-1:0] sample_strobe,
	output logic [hrci_pkg::NODES-1:0] error_ignored,
	// Output scaling
	input wire logic scale_start,
	input wire logic [7:0] scale_unit,
	input wire logic [15:0] scale_value,
	input wire logic [15:0] scale_null,
	input wire logic [15:0] scale_span,
	output logic [15:0] scale_out,
	output logic scale_done
);
	import hrci_pkg::*;

	// ------------------------------------------------------------
	// Link decode
	// ------------------------------------------------------------
	logic [15:0] mem [MEM_WORDS];
	logic [15:0] reg_off;
	logic [4:0] idx;
	logic hit;
	logic take;
	logic host_wr;

	// Register number minus one splits into node and local offset
	assign reg_off = link.addr - 16'h0001;
	assign idx = {1'b0, reg_off[3:0]} + 5'd1;
	assign hit = (link.addr != 16'h0000) && (reg_off[15:MEM_AW] == '0);
	assign take = link.req && !link.ack;
	// Acknowledge register is read-only to the host
	assign host_wr = take && link.we && hit && (idx != IDX_ACK);

	// Answer one cycle after the request is taken
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			link.ack <= 1'b0;
			link.err <= 1'b0;
			link.rdata <= RST_WORD;
		end else begin
			link.ack <= take;
			link.err <= take && !hit;
			if (take) begin
				link.rdata <= hit ? mem[reg_off[MEM_AW-1:0]] : RST_WORD;
			end
		end
	end

	// ------------------------------------------------------------
	// Command decode
	// ------------------------------------------------------------
	logic pend;
	logic [1:0] pend_node;
	logic [15:0] cword;
	logic [15:0] cdata;
	logic [7:0] code;
	logic [7:0] arg;
	logic gw;
	logic tnode_ok;
	logic [1:0] tnode;
	logic do_reset;
	logic do_ignore;
	logic do_disable;
	logic do_sample;
	logic do_plo;
	logic do_phi;
	logic known;

	// A write to the control word arms one command
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pend <= 1'b0;
			pend_node <= 2'b00;
		end else begin
			pend <= host_wr && (idx == IDX_CTRL);
			pend_node <= reg_off[5:4];
		end
	end

	// Data register is read here, so it must already hold the value
	assign cword = mem[{pend_node, OFF_CTRL}];
	assign cdata = mem[{pend_node, OFF_DATA}];
	assign code = cword[15:8];
	assign arg = cword[7:0];
	assign gw = pend && (pend_node == 2'b00);
	assign tnode_ok = (arg >= NODE_FIRST) && (arg <= NODE_LAST)
		&& (arg < 8'(NODES));
	assign tnode = arg[1:0];
	assign do_reset = gw && tnode_ok && (code == CODE_RESET_ERR);
	assign do_ignore = gw && tnode_ok && (code == CODE_IGNORE_ERR);
	assign do_disable = gw && tnode_ok && (code == CODE_DISABLE_ERR);
	assign do_sample = pend && (code == CODE_WRITE_IO1)
		&& (arg == PARAM_SAMPLE);
	assign do_plo = pend && (code == CODE_PRESET_LO);
	assign do_phi = pend && (code == CODE_PRESET_HI);
	assign known = do_reset || do_ignore || do_disable || do_sample
		|| do_plo || do_phi;

	// ------------------------------------------------------------
	// Error message capture
	// ------------------------------------------------------------
	logic [1:0] enode;
	logic [5:0] emsg_addr;
	logic [15:0] cur_msg;
	logic err_store;

	assign enode = err_node[1:0];
	assign emsg_addr = {enode, OFF_MSG};

	// Same-cycle clears are seen first so a new error is not lost
	always_comb begin
		cur_msg = mem[emsg_addr];
		if (host_wr && (reg_off[MEM_AW-1:0] == emsg_addr)) begin
			cur_msg = link.wdata;
		end
		if (do_reset && (tnode == enode)) begin
			cur_msg = RST_WORD;
		end
		if (do_disable && (tnode == enode)) begin
			cur_msg = MSG_DISABLED;
		end
	end

	// Zero never replaces anything; higher code wins priority
	assign err_store = err_valid && (err_node < 8'(NODES))
		&& !error_ignored[enode] && (cur_msg != MSG_DISABLED)
		&& (err_code != 8'h00)
		&& ({8'h00, err_code} > cur_msg);

	// ------------------------------------------------------------
	// Holding register file
	// ------------------------------------------------------------
	// Device zeroes a message only on reset, the reset command or a host write to it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < MEM_WORDS; i++) begin
				mem[i] <= RST_WORD;
			end
		end else begin
			if (host_wr) begin
				mem[reg_off[MEM_AW-1:0]] <= link.wdata;
			end
			if (known) begin
				mem[{pend_node, OFF_ACK}] <= cword;
			end
			if (do_reset) begin
				mem[{tnode, OFF_MSG}] <= RST_WORD;
			end
			if (do_disable) begin
				mem[{tnode, OFF_MSG}] <= MSG_DISABLED;
			end
			if (err_store) begin
				mem[emsg_addr] <= {8'h00, err_code};
			end
		end
	end

	// Ignore flag per node, cleared by the reset command
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			error_ignored <= '0;
		end else begin
			if (do_reset) begin
				error_ignored[tnode] <= 1'b0;
			end
			if (do_ignore) begin
				error_ignored[tnode] <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// Event counters
	// ------------------------------------------------------------
	// Preset beats a coincident count on the half it loads
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			event_count <= '0;
		end else begin
			for (int n = 0; n < NODES; n++) begin
				for (int k = 0; k < 2; k++) begin
					if (count_pulse[n][k]) begin
						event_count[n][k] <= event_count[n][k] + 32'd1;
					end
					if (pend_node == 2'(n) && arg[k]) begin
						if (do_plo) begin
							event_count[n][k][15:0] <= cdata;
						end
						if (do_phi) begin
							event_count[n][k][31:16] <= cdata;
						end
					end
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Sample timing
	// ------------------------------------------------------------
	logic [31:0] tick_cnt;
	logic tick;
	logic [NODES-1:0][15:0] samp_cnt;

	assign tick = (tick_cnt == 32'(TICK_CYCLES - 1));

	// Shared base tick of 62.5 ms
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt <= 32'h0000_0000;
		end else begin
			tick_cnt <= tick ? 32'h0000_0000 : tick_cnt + 32'd1;
		end
	end

	// Interval of zero stops sampling; a rewrite restarts the count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sample_interval <= '0;
			samp_cnt <= '0;
			sample_strobe <= '0;
		end else begin
			for (int n = 0; n < NODES; n++) begin
				sample_strobe[n] <= 1'b0;
				if (do_sample && pend_node == 2'(n)) begin
					sample_interval[n] <= cdata;
					samp_cnt[n] <= 16'h0000;
				end else if (tick && sample_interval[n] != 16'h0000) begin
					if (samp_cnt[n] + 16'd1 >= sample_interval[n]) begin
						samp_cnt[n] <= 16'h0000;
						sample_strobe[n] <= 1'b1;
					end else begin
						samp_cnt[n] <= samp_cnt[n] + 16'd1;
					end
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Output unit scaling
	// ------------------------------------------------------------
	logic [15:0] s_full;
	logic [15:0] s_base;
	logic s_signed;
	logic s_pass;
	logic [17:0] diff;
	logic [33:0] prod;
	logic [33:0] quo;
	logic [15:0] scaled;

	// One wide divider: slow path, but only used once per request
	always_comb begin
		s_full = 16'h0000;
		s_base = 16'h0000;
		s_signed = 1'b0;
		s_pass = 1'b0;
		case (scale_unit)
			UNIT_MA_0_20: s_full = FS_20MA;
			UNIT_SMA_4_20A, UNIT_SMA_4_20B: begin
				s_base = BASE_4MA;
				s_full = FS_16MA;
				s_signed = 1'b1;
			end
			UNIT_V_0_10: s_full = FS_10V;
			UNIT_CNT16: s_pass = 1'b1;
			UNIT_MA_4_20: begin
				s_base = BASE_4MA;
				s_full = FS_16MA;
			end
			default: ;
		endcase
		if (s_signed) begin
			diff = {{2{scale_value[15]}}, scale_value}
				- {{2{scale_null[15]}}, scale_null};
		end else begin
			diff = {2'b00, scale_value} - {2'b00, scale_null};
		end
		prod = 34'(diff[16:0]) * 34'(s_full);
		if (scale_span == 16'h0000) begin
			quo = 34'(s_full);
		end else begin
			quo = prod / 34'(scale_span);
		end
		if (quo > 34'(s_full)) begin
			quo = 34'(s_full);
		end
		if (diff[17]) begin
			quo = 34'h0;
		end
		scaled = s_pass ? scale_value : s_base + quo[15:0];
	end

	// Result held until the next request
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scale_out <= 16'h0000;
			scale_done <= 1'b0;
		end else begin
			scale_done <= scale_start;
			if (scale_start) begin
				scale_out <= scaled;
			end
		end
	end

endmodule : hrci_device
`default_nettype wire

/* File: rtl/hrci_host.sv */
`timescale 1ns/100ps
`default_nettype none
module hrci_host (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Holding register link
	hrci_link_if.host link
);
	import hrci_pkg::*;

	// ------------------------------------------------------------
	// Software registers
	// ------------------------------------------------------------
	hrci_hstate_t state;
	logic [7:0] hc_node;
	logic [15:0] hc_addr;
	logic [15:0] hc_word;
	logic [15:0] hc_data;
	logic [15:0] hc_rdata;
	logic done;
	logic match;
	logic lerr;
	logic [4:0] polls;
	logic mapped;
	logic wr;
	logic go;
	logic [15:0] base;

	assign mapped = (paddr == HA_GO) || (paddr == HA_NODE)
		|| (paddr == HA_ADDR) || (paddr == HA_WORD) || (paddr == HA_DATA)
		|| (paddr == HA_STATUS) || (paddr == HA_RDATA);
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign wr = psel && penable && pwrite && mapped;
	// Start is ignored while a sequence runs
	assign go = wr && (paddr == HA_GO) && (state == H_IDLE);
	assign base = {4'h0, hc_node, 4'h0};

	// Read data latched in setup so it stands through access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable) begin
			unique case (paddr)
				HA_NODE: prdata <= {24'h0, hc_node};
				HA_ADDR: prdata <= {16'h0, hc_addr};
				HA_WORD: prdata <= {16'h0, hc_word};
				HA_DATA: prdata <= {16'h0, hc_data};
				HA_STATUS: prdata <= {28'h0, lerr, match, done,
					state != H_IDLE};
				HA_RDATA: prdata <= {16'h0, hc_rdata};
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end

	// Plain configuration registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hc_node <= 8'h00;
			hc_addr <= 16'h0000;
			hc_word <= 16'h0000;
			hc_data <= 16'h0000;
		end else if (wr) begin
			if (paddr == HA_NODE) hc_node <= pwdata[7:0];
			if (paddr == HA_ADDR) hc_addr <= pwdata[15:0];
			if (paddr == HA_WORD) hc_word <= pwdata[15:0];
			if (paddr == HA_DATA) hc_data <= pwdata[15:0];
		end
	end

	// ------------------------------------------------------------
	// Link sequencer
	// ------------------------------------------------------------
	// Data first, then control, then poll the acknowledge echo
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= H_IDLE;
			link.req <= 1'b0;
			link.we <= 1'b0;
			link.addr <= 16'h0000;
			link.wdata <= 16'h0000;
			hc_rdata <= 16'h0000;
			done <= 1'b0;
			match <= 1'b0;
			lerr <= 1'b0;
			polls <= 5'd0;
		end else begin
			unique case (state)
				H_IDLE: begin
					if (go && (pwdata[GO_PARAM] || pwdata[GO_READ]
						|| pwdata[GO_WRITE])) begin
						done <= 1'b0;
						match <= 1'b0;
						lerr <= 1'b0;
						polls <= 5'd0;
						link.req <= 1'b1;
						if (pwdata[GO_PARAM]) begin
							state <= H_DATA;
							link.we <= 1'b1;
							link.addr <= base + 16'(IDX_DATA);
							link.wdata <= hc_data;
						end else begin
							state <= H_RAW;
							link.we <= pwdata[GO_WRITE];
							link.addr <= hc_addr;
							link.wdata <= hc_data;
						end
					end
				end
				H_DATA: begin
					if (link.ack) begin
						state <= H_CTRL;
						link.addr <= base + 16'(IDX_CTRL);
						link.wdata <= hc_word;
						lerr <= link.err;
					end
				end
				H_CTRL: begin
					if (link.ack) begin
						state <= H_POLL;
						link.we <= 1'b0;
						link.addr <= base + 16'(IDX_ACK);
						lerr <= lerr || link.err;
					end
				end
				H_POLL: begin
					if (link.ack) begin
						hc_rdata <= link.rdata;
						polls <= polls + 5'd1;
						if (link.rdata == hc_word || link.err
							|| polls == 5'(POLL_MAX - 1)) begin
							state <= H_IDLE;
							link.req <= 1'b0;
							done <= 1'b1;
							match <= (link.rdata == hc_word) && !link.err;
							lerr <= lerr || link.err;
						end
					end
				end
				H_RAW: begin
					if (link.ack) begin
						state <= H_IDLE;
						link.req <= 1'b0;
						hc_rdata <= link.rdata;
						done <= 1'b1;
						lerr <= link.err;
					end
				end
			endcase
		end
	end

endmodule : hrci_host
`default_nettype wire

/* File: verif/hrci_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
// ----
// Link checker, watches both ends
// ----
module hrci_monitor (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Link signals
	input wire logic req,
	input wire logic we,
	input wire logic [15:0] addr,
	input wire logic [15:0] wdata,
	input wire logic [15:0] rdata,
	input wire logic ack,
	input wire logic err
);
	logic take;
	logic [15:0] last_wr;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	assign take = req && !ack;
	// Last written register; a control write must follow its data
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_wr <= 16'h0000;
		end else if (take && we) begin
			last_wr <= addr;
		end
	end
	ack_latency_a: assert property (take |=> ack)
		else $error("link answer late");
	ack_pulse_a: assert property (ack |=> !ack)
		else $error("link answer too long");
	low_addr_a: assert property (take && addr == 16'h0000 |=> err)
		else $error("register zero not refused");
	high_addr_a: assert property (take && addr > 16'h0040 |=> err)
		else $error("register past last node not refused");
	mapped_ok_a: assert property (
		take && addr inside {[16'h0001:16'h0040]} |=> !err)
		else $error("mapped register refused");
	err_data_a: assert property (err |-> ack && rdata == 16'h0000)
		else $error("refused access returned data");
	req_hold_a: assert property (
		take |=> req && $stable(addr) && $stable(we) && $stable(wdata))
		else $error("request changed before answer");
	// Host may keep req up to re-poll, so only the refusal pulse is checked
	err_pulse_a: assert property (err |=> !err)
		else $error("refusal held too long");
	data_first_a: assert property (
		take && we && addr[3:0] == 4'hf |-> last_wr == addr + 16'h0001)
		else $error("control written without its data");
endmodule : hrci_monitor
`default_nettype wire

/* File: verif/test_hrci.sv */
`timescale 1ns/100ps
`default_nettype none
module test_hrci;
	import hrci_pkg::*;
	localparam int TICKS = 20;
	// ----
	// Signals and model state
	// ----
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, perr;
	logic [7:0] paddr, err_node, err_code, scale_unit;
	logic [31:0] pwdata, prdata, rd, st;
	logic err_valid, scale_start, scale_done;
	logic [15:0] scale_value, scale_null, scale_span, scale_out;
	logic [NODES-1:0][1:0] count_pulse;
	logic [NODES-1:0][1:0][31:0] event_count;
	logic [NODES-1:0][15:0] sample_interval;
	logic [NODES-1:0] sample_strobe, error_ignored;
	int n_fail = 0;
	int n_tests = 0;
	int cyc = 0;
	longint cnt_m [NODES][2];
	hrci_link_if link ();
	hrci_host i_hrci_host (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
	hrci_device #(.TICK_CYCLES(TICKS)) i_hrci_device (.pclk(pclk),
		.presetn(presetn), .link(link), .err_valid(err_valid),
		.err_node(err_node), .err_code(err_code), .count_pulse(count_pulse),
		.event_count(event_count), .sample_interval(sample_interval),
		.sample_strobe(sample_strobe), .error_ignored(error_ignored),
		.scale_start(scale_start), .scale_unit(scale_unit),
		.scale_value(scale_value), .scale_null(scale_null),
		.scale_span(scale_span), .scale_out(scale_out),
		.scale_done(scale_done));
	hrci_monitor i_hrci_monitor (.pclk(pclk), .presetn(presetn),
		.req(link.req), .we(link.we), .addr(link.addr), .wdata(link.wdata),
		.rdata(link.rdata), .ack(link.ack), .err(link.err));
	// Clock
	initial begin
		pclk = 1'b0;
		forever begin
			#2.5 pclk = ~pclk;
		end
	end
	// Cycle ceiling and event counter model
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 50000) begin
			n_fail++;
			stop_test();
		end
		for (int n = 0; n < NODES; n++) begin
			for (int k = 0; k < 2; k++) begin
				if (count_pulse[n][k] === 1'b1) begin
					cnt_m[n][k]++;
				end
			end
		end
	end
	// ----
	// Tasks
	// ----
	task automatic check(string what, logic [31:0] exp, logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	// One APB transfer; an idle cycle after it keeps strobes single
	task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		rd = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic run(logic [31:0] go);
		apb(1'b1, HA_GO, go);
		rd = 32'h0;
		while (rd[ST_DONE] !== 1'b1) begin
			apb(1'b0, HA_STATUS, 32'h0);
		end
	endtask : run
	task automatic param(logic [7:0] node, logic [15:0] w, logic [15:0] d);
		apb(1'b1, HA_NODE, 32'(node));
		apb(1'b1, HA_WORD, 32'(w));
		apb(1'b1, HA_DATA, 32'(d));
		run(32'h1);
	endtask : param
	task automatic raw_rd(logic [15:0] a);
		apb(1'b1, HA_ADDR, 32'(a));
		run(32'h2);
		st = rd;
		apb(1'b0, HA_RDATA, 32'h0);
	endtask : raw_rd
	task automatic raw_wr(logic [15:0] a, logic [15:0] d);
		apb(1'b1, HA_ADDR, 32'(a));
		apb(1'b1, HA_DATA, 32'(d));
		run(32'h4);
	endtask : raw_wr
	// Report an error on a node, then read back its message register
	task automatic em(logic [7:0] node, logic [7:0] code, logic [15:0] exp);
		err_node <= node;
		err_code <= code;
		err_valid <= 1'b1;
		@(posedge pclk);
		err_valid <= 1'b0;
		raw_rd(16'(node) * 16'd16 + 16'd8);
		check("message", 32'(exp), rd);
	endtask : em
	task automatic chk_cnt();
		for (int n = 0; n < NODES; n++) begin
			for (int k = 0; k < 2; k++) begin
				check("counter", 32'(cnt_m[n][k]), event_count[n][k]);
			end
		end
	endtask : chk_cnt
	// Expected scaler output, in uA, mV or raw counts
	function automatic logic [15:0] scale_exp(logic [7:0] u,
		logic [15:0] v, logic [15:0] nl, logic [15:0] s);
		longint full, base, diff, q;
		base = 0;
		case (u)
			8'h07: full = 20000;
			8'h08, 8'h09: begin
				full = 16000;
				base = 4000;
			end
			8'h0a: full = 10000;
			8'h0b: return v;
			8'h0c: begin
				full = 16000;
				base = 4000;
			end
			default: return 16'h0000;
		endcase
		diff = longint'(v) - longint'(nl);
		if (u == 8'h08 || u == 8'h09) begin
			diff = longint'($signed(v)) - longint'($signed(nl));
		end
		// Below null always gives the base, even with no span set
		q = (diff < 0) ? 0 : ((s == 16'h0000) ? full : diff * full / longint'(s));
		q = (q < 0) ? 0 : ((q > full) ? full : q);
		return 16'(base + q);
	endfunction : scale_exp
	task automatic stop_test();
		$display("Checks %0d, mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : stop_test
	// ----
	// Main sequence
	// ----
	initial begin
		logic [15:0] hi, lo;
		int t0;
		{psel, penable, pwrite, err_valid, scale_start} = '0;
		{paddr, pwdata, err_node, err_code, scale_unit} = '0;
		{scale_value, scale_null, scale_span} = '0;
		count_pulse = '0;
		presetn = 1'b0;
		void'($urandom(10));
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		// Sample interval write, echoed into the acknowledge register
		param(8'd2, 16'h8103, 16'h3840);
		check("match", 32'h1, 32'(rd[ST_MATCH]));
		check("interval", 32'h3840, 32'(sample_interval[2]));
		raw_rd(16'd39);
		check("ack", 32'h8103, rd);
		param(8'd1, 16'h8103, 16'h0002);
		do @(posedge pclk); while (sample_strobe[1] !== 1'b1);
		t0 = cyc;
		do @(posedge pclk); while (sample_strobe[1] !== 1'b1);
		check("strobe gap", 32'(2 * TICKS), 32'(cyc - t0));
		// Counter presets for every non-zero select mask, then counting
		for (int m = 1; m < 4; m++) begin
			hi = 16'($urandom);
			lo = 16'($urandom);
			param(8'd3, {CODE_PRESET_HI, 8'(m)}, hi);
			param(8'd3, {CODE_PRESET_LO, 8'(m)}, lo);
			raw_rd(16'd55);
			check("preset ack", {16'h0, CODE_PRESET_LO, 8'(m)}, rd);
			for (int k = 0; k < 2; k++) begin
				if (m[k]) begin
					cnt_m[3][k] = {hi, lo};
				end
			end
			chk_cnt();
		end
		repeat (50) begin
			count_pulse <= 8'($urandom);
			@(posedge pclk);
		end
		count_pulse <= '0;
		@(posedge pclk);
		chk_cnt();
		// Error messages on node 1 through gateway commands
		em(8'd1, 8'd5, 16'd5);
		em(8'd1, 8'd3, 16'd5);
		param(8'd0, 16'h0401, 16'h0);
		em(8'd1, 8'd0, 16'd0);
		raw_wr(16'd24, 16'd7);
		em(8'd1, 8'd0, 16'd7);
		param(8'd0, 16'h0601, 16'h0);
		em(8'd1, 8'd12, 16'd254);
		param(8'd0, 16'h0401, 16'h0);
		raw_wr(16'd24, 16'h00fe);
		em(8'd1, 8'd3, 16'd254);
		raw_wr(16'd24, 16'h0);
		param(8'd0, 16'h0501, 16'h0);
		check("ignored", 32'h1, 32'(error_ignored[1]));
		em(8'd1, 8'd4, 16'd0);
		param(8'd0, 16'h0401, 16'h0);
		check("ignored", 32'h0, 32'(error_ignored[1]));
		em(8'd1, 8'd6, 16'd6);
		param(8'd2, 16'h0401, 16'h0);
		check("node match", 32'h0, 32'(rd[ST_MATCH]));
		em(8'd1, 8'd2, 16'd6);
		raw_rd(16'd39);
		check("node ack", 32'h8103, rd);
		param(8'd0, 16'h7701, 16'h0);
		raw_rd(16'd7);
		check("gateway ack", 32'h0401, rd);
		// Register range and bad host addresses
		raw_wr(16'd16, 16'h5a3c);
		raw_rd(16'd16);
		check("gateway data", 32'h5a3c, rd);
		raw_rd(16'd0);
		check("addr 0", 32'h1, 32'(st[ST_LERR]));
		raw_rd(16'd65);
		check("addr 65", 32'h1, 32'(st[ST_LERR]));
		raw_rd(16'd64);
		check("addr 64", 32'h0, 32'(st[ST_LERR]));
		apb(1'b0, 8'h1c, 32'h0);
		check("apb refuse", 32'h1, 32'(perr));
		// Scaler over every unit code and one unknown
		for (int u = 7; u < 14; u++) begin
			for (int j = 0; j < 3; j++) begin
				scale_unit <= 8'(u);
				scale_value <= 16'($urandom);
				scale_null <= 16'($urandom);
				scale_span <= (j == 0) ? 16'h0 : 16'($urandom & 32'h7fff);
				scale_start <= 1'b1;
				@(posedge pclk);
				scale_start <= 1'b0;
				#1;
				check("scale done", 32'h1, 32'(scale_done));
				check("scale out", 32'(scale_exp(scale_unit, scale_value,
					scale_null, scale_span)), 32'(scale_out));
				@(posedge pclk);
			end
		end
		stop_test();
	end
endmodule : test_hrci
`default_nettype wire
